// ### include/dsfs_pkg.sv
// shared constants and types of the drive submode and feedback select block
package dsfs_pkg;
	// object dictionary indices
	localparam logic [15:0] IDX_SUBMODE = 16'h3202;
	localparam logic [15:0] IDX_FB_SELECT = 16'h3203;
	localparam logic [15:0] IDX_FB_MAP = 16'h3204;
	localparam logic [7:0] SUB_COUNT = 8'h00;
	localparam logic [7:0] SUB_FIRST = 8'h01;
	// feedback tables: sensorless entry first, three feedbacks in all
	localparam logic [7:0] FB_COUNT = 8'h03;
	localparam logic [15:0] FB_MAP_FIRST = 16'h3380;
	localparam logic [15:0] FB_MAP_SECOND = 16'h3390;
	localparam logic [15:0] FB_MAP_THIRD = 16'h33A0;
	// reset values
	localparam logic [31:0] SUBMODE_RESET = 32'h00000000;
	localparam logic [7:0] FB_SELECT_RESET = 8'h00;
	// bit positions inside one feedback selection byte
	localparam int MASK_POS = 0;
	localparam int MASK_VEL = 1;
	localparam int MASK_COMM = 2;
	localparam int MASK_COUNT = 3;
	// operating mode codes that allow pure torque control
	localparam logic [7:0] MODE_PROFILE_TORQUE = 8'h04;
	localparam logic [7:0] MODE_CYCLIC_TORQUE = 8'h0A;
	// sensor numbers: 1 is the sensorless feedback, search starts at 2
	localparam logic [1:0] SENSORLESS = 2'h1;
	localparam int SEARCH_START = 1;
	localparam int FB_ENTRIES = 3;

	typedef logic [1:0] dsfs_sensor_t;
	typedef logic [FB_ENTRIES-1:0][7:0] dsfs_masks_t;

	// submode word, bit 0 upward: loop, ramp sim, brake, current, align,
	// torque, motor type, slow speed; upper bits are kept but unused
	typedef struct packed {
		logic [23:0] spare;
		logic slowSpeed;
		logic brushlessMotorType;
		logic torqueOnly;
		logic rotorSelfAlignment;
		logic currentLowering;
		logic brakeAuto;
		logic speedRampSimulation;
		logic loopTypeSelect;
	} dsfs_submode_s;

	// sensor chosen for each controller
	typedef struct packed {
		dsfs_sensor_t comm;
		dsfs_sensor_t vel;
		dsfs_sensor_t pos;
	} dsfs_src_s;

	typedef enum logic [1:0] {
		LOOP_OPEN,
		LOOP_WAIT_INDEX,
		LOOP_ALIGN,
		LOOP_CLOSED
	} dsfs_loop_e;
endpackage : dsfs_pkg

// ### logic/dsfs_feedback_search.sv
// first-match sensor search for one controller over the active masks
`timescale 1ns/10ps
module dsfs_feedback_search #(
	parameter int MASK_BIT = 0
) (
	input wire dsfs_pkg::dsfs_masks_t masks,
	output dsfs_pkg::dsfs_sensor_t sensor
);
	// scan downward so the lowest matching entry wins; sensorless if none
	always_comb begin
		sensor = dsfs_pkg::SENSORLESS;
		for (int i = dsfs_pkg::FB_ENTRIES - 1; i >= dsfs_pkg::SEARCH_START; i--) begin
			if (masks[i][MASK_BIT]) begin
				sensor = 2'(i + 1); // [RULE_15]
			end
		end
	end
endmodule : dsfs_feedback_search

// ### logic/dsfs_loop_seq.sv
// open to closed loop sequencer with alignment and index wait
`timescale 1ns/10ps
module dsfs_loop_seq (
	input wire logic clk,
	input wire logic reset,
	input wire logic wantClosed,
	input wire logic selfAlign,
	input wire logic commHasIndex,
	input wire logic indexSeen,
	input wire logic alignDone,
	output logic closedRun,
	output logic alignRun
);
	dsfs_pkg::dsfs_loop_e state_r;

	// leaving closed loop selection always drops back to open loop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= dsfs_pkg::LOOP_OPEN;
		end else if (!wantClosed) begin
			state_r <= dsfs_pkg::LOOP_OPEN; // [RULE_01]
		end else begin
			unique case (state_r)
				dsfs_pkg::LOOP_OPEN: begin
					// no index on the encoder forces alignment
					if (selfAlign || !commHasIndex) begin
						state_r <= dsfs_pkg::LOOP_ALIGN; // [RULE_06] [RULE_08]
					end else begin
						state_r <= dsfs_pkg::LOOP_WAIT_INDEX; // [RULE_07]
					end
				end
				dsfs_pkg::LOOP_WAIT_INDEX: begin
					// an encoder that loses its index while we wait can never close
					if (!commHasIndex) begin
						state_r <= dsfs_pkg::LOOP_ALIGN; // [RULE_08]
					end else if (indexSeen) begin
						state_r <= dsfs_pkg::LOOP_CLOSED; // [RULE_07]
					end
				end
				dsfs_pkg::LOOP_ALIGN: begin
					if (alignDone) begin
						state_r <= dsfs_pkg::LOOP_CLOSED; // [RULE_06]
					end
				end
				dsfs_pkg::LOOP_CLOSED: begin
					state_r <= dsfs_pkg::LOOP_CLOSED;
				end
			endcase
		end
	end

	assign closedRun = (state_r == dsfs_pkg::LOOP_CLOSED);
	assign alignRun = (state_r == dsfs_pkg::LOOP_ALIGN);
endmodule : dsfs_loop_seq

// ### logic/dsfs_submode_select.sv
// submode word, feedback selection and mapping objects of the drive
`timescale 1ns/10ps
// What this block does
// RULE_01: submode bit 0 picks open loop at zero, closed loop at one.
// RULE_02: loop type cannot change while operation is enabled.
// RULE_03: ramp simulation flag runs speed modes as S-ramp position changes.
// RULE_04: brake flag enables automatic holding brake control.
// RULE_05: current lowering flag reduces winding current in open loop only.
// RULE_06: with closed loop and alignment flag, align in open loop then close.
// RULE_07: without alignment, stay open loop until encoder index is seen.
// RULE_08: encoder without index always forces alignment.
// RULE_09: torque flag alone acts only in the two torque modes.
// RULE_10: motor type flag marks a brushless DC motor.
// RULE_11: slow speed mode needs closed loop already running.
// RULE_12: selection writes while enabled wait for next entry into enabled.
// RULE_13: selection byte bits: 0 position, 1 velocity, 2 commutation.
// RULE_14: first entry is always the sensorless feedback.
// RULE_15: search from sensor 2 upward, first set mask bit wins.
// RULE_16: open loop ignores commutation bit, keeps position and velocity.
// RULE_17: both tables report three entries.
// RULE_18: mapping entries read 3380, 3390 and 33A0.
// RULE_19: each submode flag has its own fixed bit.
module dsfs_submode_select (
	input wire logic clk,
	input wire logic reset,
	input wire logic opEnabled,
	input wire logic [7:0] opMode,
	input wire logic commHasIndex,
	input wire logic indexSeen,
	input wire logic alignDone,
	input wire logic [15:0] objIndex,
	input wire logic [7:0] objSub,
	input wire logic objWr,
	input wire logic objRd,
	input wire logic [31:0] objWrData,
	output logic [31:0] objRdData,
	output logic objAck,
	output logic objErr,
	output logic loopClosed,
	output logic alignActive,
	output logic speedSimOn,
	output logic brakeAutoOn,
	output logic currentLowerOn,
	output logic torqueOnlyOn,
	output logic brushlessOn,
	output logic slowSpeedOn,
	output dsfs_pkg::dsfs_src_s fbSrc
);
	dsfs_pkg::dsfs_submode_s submode_r;
	dsfs_pkg::dsfs_masks_t selBuf_r;
	dsfs_pkg::dsfs_masks_t selActive_r;
	logic opEnPrev_r;
	logic closedRun;
	logic alignRun;
	logic hitSub;
	logic hitSel;
	logic hitMap;
	logic subInTable;
	logic [1:0] entry;
	logic wrOk;
	logic loopRefused;
	logic [31:0] rdVal;
	logic rdOk;
	logic [dsfs_pkg::MASK_COUNT-1:0][1:0] found;

	// object decode
	assign hitSub = (objIndex == dsfs_pkg::IDX_SUBMODE) && (objSub == dsfs_pkg::SUB_COUNT);
	assign hitSel = (objIndex == dsfs_pkg::IDX_FB_SELECT);
	assign hitMap = (objIndex == dsfs_pkg::IDX_FB_MAP);
	assign subInTable = (objSub >= dsfs_pkg::SUB_FIRST) && (objSub <= dsfs_pkg::FB_COUNT);
	assign entry = objSub[1:0] - 2'h1;
	assign wrOk = hitSub || (hitSel && subInTable);
	// a loop change while enabled is refused and flagged
	assign loopRefused = hitSub && opEnabled &&
		(objWrData[0] != submode_r.loopTypeSelect); // [RULE_02]

	// read mux; counts and mapping table are constants
	always_comb begin
		rdVal = 32'h00000000;
		rdOk = 1'b0;
		if (hitSub) begin
			rdVal = submode_r;
			rdOk = 1'b1;
		end else if ((hitSel || hitMap) && objSub == dsfs_pkg::SUB_COUNT) begin
			rdVal = {24'h000000, dsfs_pkg::FB_COUNT}; // [RULE_17]
			rdOk = 1'b1;
		end else if (hitSel && subInTable) begin
			rdVal = {24'h000000, selBuf_r[entry]};
			rdOk = 1'b1;
		end else if (hitMap && subInTable) begin
			rdOk = 1'b1;
			unique case (entry)
				2'h0: rdVal = {16'h0000, dsfs_pkg::FB_MAP_FIRST}; // [RULE_18] [RULE_14]
				2'h1: rdVal = {16'h0000, dsfs_pkg::FB_MAP_SECOND}; // [RULE_18]
				default: rdVal = {16'h0000, dsfs_pkg::FB_MAP_THIRD}; // [RULE_18]
			endcase
		end
	end

	// submode word; bit 0 keeps its value while enabled
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			submode_r <= dsfs_pkg::SUBMODE_RESET;
		end else if (objWr && hitSub) begin
			submode_r <= objWrData; // [RULE_19]
			if (opEnabled) begin
				submode_r.loopTypeSelect <= submode_r.loopTypeSelect; // [RULE_02]
			end
		end
	end

	// host-visible selection buffer, written at any time
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			selBuf_r <= {dsfs_pkg::FB_ENTRIES{dsfs_pkg::FB_SELECT_RESET}};
		end else if (objWr && hitSel && subInTable) begin
			selBuf_r[entry] <= objWrData[7:0]; // [RULE_13]
		end
	end

	// masks in use are taken only on the edge into operation enabled,
	// so a write during a move can never switch sensors under the motor
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			opEnPrev_r <= 1'b0;
			selActive_r <= {dsfs_pkg::FB_ENTRIES{dsfs_pkg::FB_SELECT_RESET}};
		end else begin
			opEnPrev_r <= opEnabled;
			if (opEnabled && !opEnPrev_r) begin
				selActive_r <= selBuf_r; // [RULE_12]
			end
		end
	end

	// access answer one cycle after the request; write wins over read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			objAck <= 1'b0;
			objErr <= 1'b0;
			objRdData <= 32'h00000000;
		end else begin
			objAck <= objWr || objRd;
			if (objWr) begin
				objErr <= !wrOk || loopRefused; // [RULE_02]
				objRdData <= 32'h00000000;
			end else if (objRd) begin
				objErr <= !rdOk;
				objRdData <= rdVal;
			end else begin
				objErr <= 1'b0;
				objRdData <= 32'h00000000;
			end
		end
	end

	dsfs_loop_seq loopSeq (
		.clk(clk),
		.reset(reset),
		.wantClosed(submode_r.loopTypeSelect),
		.selfAlign(submode_r.rotorSelfAlignment),
		.commHasIndex(commHasIndex),
		.indexSeen(indexSeen),
		.alignDone(alignDone),
		.closedRun(closedRun),
		.alignRun(alignRun)
	);

	// one search per controller: position, velocity, commutation
	for (genvar g = 0; g < dsfs_pkg::MASK_COUNT; g++) begin : gSearch
		dsfs_feedback_search #(
			.MASK_BIT(g)
		) search (
			.masks(selActive_r),
			.sensor(found[g])
		);
	end

	// registered mode outputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			loopClosed <= 1'b0;
			alignActive <= 1'b0;
			speedSimOn <= 1'b0;
			brakeAutoOn <= 1'b0;
			currentLowerOn <= 1'b0;
			torqueOnlyOn <= 1'b0;
			brushlessOn <= 1'b0;
			slowSpeedOn <= 1'b0;
		end else begin
			loopClosed <= closedRun; // [RULE_01] [RULE_07]
			alignActive <= alignRun; // [RULE_06]
			speedSimOn <= submode_r.speedRampSimulation; // [RULE_03]
			brakeAutoOn <= submode_r.brakeAuto; // [RULE_04]
			currentLowerOn <= submode_r.currentLowering && !closedRun; // [RULE_05]
			torqueOnlyOn <= submode_r.torqueOnly &&
				(opMode == dsfs_pkg::MODE_PROFILE_TORQUE ||
				opMode == dsfs_pkg::MODE_CYCLIC_TORQUE); // [RULE_09]
			brushlessOn <= submode_r.brushlessMotorType; // [RULE_10]
			slowSpeedOn <= submode_r.slowSpeed && closedRun; // [RULE_11]
		end
	end

	// sources; commutation falls back to sensorless in open loop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fbSrc <= {3{dsfs_pkg::SENSORLESS}};
		end else begin
			fbSrc.pos <= found[dsfs_pkg::MASK_POS]; // [RULE_15]
			fbSrc.vel <= found[dsfs_pkg::MASK_VEL]; // [RULE_16]
			fbSrc.comm <= submode_r.loopTypeSelect ?
				found[dsfs_pkg::MASK_COMM] : dsfs_pkg::SENSORLESS; // [RULE_16]
		end
	end

	AST_LOOP_LOCKED: assert property ( // [RULE_02]
		@(posedge clk) disable iff (reset)
		(objWr && hitSub && opEnabled) |=> $stable(submode_r.loopTypeSelect))
		else $error("loop type changed while enabled");

	AST_LOOP_REFUSE_FLAG: assert property ( // [RULE_02]
		@(posedge clk) disable iff (reset)
		(objWr && loopRefused) |=> (objAck && objErr))
		else $error("refused loop change not flagged");

	AST_SEL_HELD: assert property ( // [RULE_12]
		@(posedge clk) disable iff (reset)
		(opEnPrev_r && opEnabled) |=> $stable(selActive_r))
		else $error("active masks changed while enabled");

	AST_SEL_TAKEN: assert property ( // [RULE_12]
		@(posedge clk) disable iff (reset)
		(!opEnPrev_r && opEnabled) |=> (selActive_r == $past(selBuf_r)))
		else $error("masks not taken on entry to enabled");

	AST_COUNT_READ: assert property ( // [RULE_17]
		@(posedge clk) disable iff (reset)
		(objRd && !objWr && hitSel && objSub == 8'h00)
		|=> (objAck && !objErr && objRdData == 32'h00000003))
		else $error("selection count wrong");

	AST_MAP_THIRD: assert property ( // [RULE_18]
		@(posedge clk) disable iff (reset)
		(objRd && !objWr && hitMap && objSub == 8'h03)
		|=> (objRdData == 32'h000033A0))
		else $error("third mapping entry wrong");

	AST_MAP_RO: assert property ( // [RULE_18]
		@(posedge clk) disable iff (reset)
		(objWr && hitMap) |=> objErr)
		else $error("write to mapping not refused");

	AST_TORQUE_MODE: assert property ( // [RULE_09]
		@(posedge clk) disable iff (reset)
		torqueOnlyOn |-> ($past(submode_r.torqueOnly) &&
		($past(opMode) == 8'h04 || $past(opMode) == 8'h0A)))
		else $error("torque only outside torque modes");

	AST_SLOW_NEEDS_CLOSED: assert property ( // [RULE_11]
		@(posedge clk) disable iff (reset)
		slowSpeedOn |-> loopClosed)
		else $error("slow speed without closed loop");

	AST_CUR_OPEN_ONLY: assert property ( // [RULE_05]
		@(posedge clk) disable iff (reset)
		(submode_r.currentLowering && !closedRun) |=> currentLowerOn)
		else $error("current lowering missing in open loop");

	AST_COMM_OPEN: assert property ( // [RULE_16]
		@(posedge clk) disable iff (reset)
		!submode_r.loopTypeSelect |=> (fbSrc.comm == 2'h1))
		else $error("commutation source used in open loop");

	AST_NO_INDEX_ALIGN: assert property ( // [RULE_08]
		@(posedge clk) disable iff (reset)
		(submode_r.loopTypeSelect && !closedRun && !alignRun && !commHasIndex
		&& !$past(closedRun)) |=> alignRun)
		else $error("no alignment for index-less encoder");

	AST_WAIT_INDEX: assert property ( // [RULE_07]
		@(posedge clk) disable iff (reset)
		(!alignRun && !closedRun && !indexSeen) |=> !closedRun)
		else $error("closed loop without index or alignment");

	AST_SEARCH_FIRST: assert property ( // [RULE_15]
		@(posedge clk) disable iff (reset)
		(selActive_r[1][0]) |=> (fbSrc.pos == 2'h2))
		else $error("sensor 2 not chosen first for position");

	// plain flag copies lag the stored word by exactly one cycle
	AST_SPEED_SIM: assert property ( // [RULE_03]
		@(posedge clk) disable iff (reset)
		1'b1 |=> (speedSimOn == $past(submode_r.speedRampSimulation)))
		else $error("ramp simulation output does not follow its flag");

	AST_BRAKE_AUTO: assert property ( // [RULE_04]
		@(posedge clk) disable iff (reset)
		1'b1 |=> (brakeAutoOn == $past(submode_r.brakeAuto)))
		else $error("brake output does not follow its flag");

	AST_BRUSHLESS: assert property ( // [RULE_10]
		@(posedge clk) disable iff (reset)
		1'b1 |=> (brushlessOn == $past(submode_r.brushlessMotorType)))
		else $error("motor type output does not follow its flag");

	AST_SENSORLESS_FALLBACK: assert property ( // [RULE_14]
		@(posedge clk) disable iff (reset)
		!(selActive_r[1][0] || selActive_r[2][0]) |=> (fbSrc.pos == 2'h1))
		else $error("position source not sensorless without a mask");
endmodule : dsfs_submode_select

// ### tb/test_drive_submode_and_feedback_select.sv
// self-checking bench of the submode word and feedback selection block
`timescale 1ns/10ps
module test_drive_submode_and_feedback_select;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic opEnabled = 1'b0;
	logic [7:0] opMode = 8'h00;
	logic commHasIndex = 1'b1;
	logic indexSeen = 1'b0;
	logic alignDone = 1'b0;
	logic [15:0] objIndex = 16'h0000;
	logic [7:0] objSub = 8'h00;
	logic objWr = 1'b0;
	logic objRd = 1'b0;
	logic [31:0] objWrData = 32'h00000000;
	logic [31:0] objRdData;
	logic objAck, objErr, loopClosed, alignActive, speedSimOn, brakeAutoOn;
	logic currentLowerOn, torqueOnlyOn, brushlessOn, slowSpeedOn;
	dsfs_pkg::dsfs_src_s fbSrc;
	int n_errors = 0;
	int checked = 0;
	// bench model: submode word, buffered masks, expected sources
	logic [31:0] subM = 32'h00000000;
	logic [7:0] selM [1:3];
	logic [5:0] srcM = 6'h15;
	logic [31:0] rd;
	logic er;
	logic [31:0] tmp;
	logic [7:0] modeTab [4] = '{8'h04, 8'h0A, 8'h03, 8'h01};

	always #20 clk = ~clk;

	dsfs_submode_select DUT (.clk(clk), .reset(reset), .opEnabled(opEnabled), .opMode(opMode),
		.commHasIndex(commHasIndex), .indexSeen(indexSeen), .alignDone(alignDone),
		.objIndex(objIndex), .objSub(objSub), .objWr(objWr), .objRd(objRd),
		.objWrData(objWrData), .objRdData(objRdData), .objAck(objAck), .objErr(objErr),
		.loopClosed(loopClosed), .alignActive(alignActive), .speedSimOn(speedSimOn),
		.brakeAutoOn(brakeAutoOn), .currentLowerOn(currentLowerOn),
		.torqueOnlyOn(torqueOnlyOn), .brushlessOn(brushlessOn), .slowSpeedOn(slowSpeedOn),
		.fbSrc(fbSrc));

	// one comparison, counted; four-state so an unknown never matches
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// one object access; the answer stands only in the cycle after the taking edge
	task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] d);
		@(posedge clk);
		objWr <= wr;
		objRd <= ~wr;
		objIndex <= idx;
		objSub <= sub;
		objWrData <= d;
		@(posedge clk);
		objWr <= 1'b0;
		objRd <= 1'b0;
		#1;
		rd = objRdData;
		er = objErr;
		chk({31'h0, objAck}, 32'h1, "ack");
	endtask : obj

	// pulse a level input for one cycle
	task automatic pulse(input int which);
		@(posedge clk);
		if (which == 0) indexSeen <= 1'b1;
		else alignDone <= 1'b1;
		@(posedge clk);
		indexSeen <= 1'b0;
		alignDone <= 1'b0;
	endtask : pulse

	// first set bit from sensor 2 upward wins, sensorless otherwise
	function automatic logic [5:0] search();
		logic [5:0] r;
		r = 6'h15;
		for (int b = 2; b >= 0; b--)
			for (int s = 3; s >= 2; s--)
				if (selM[s][b]) r[2*b +: 2] = s[1:0];
		if (!subM[0]) r[5:4] = 2'h1;
		return r;
	endfunction : search

	// mode outputs against the model once the loop has settled
	task automatic flags();
		logic [5:0] e;
		cyc(6);
		e[5] = subM[1];
		e[4] = subM[2];
		e[3] = subM[3] & ~subM[0];
		e[2] = subM[5] & (opMode == 8'h04 || opMode == 8'h0A);
		e[1] = subM[6];
		e[0] = subM[7] & subM[0];
		chk({31'h0, loopClosed}, {31'h0, subM[0]}, "loop");
		chk({speedSimOn, brakeAutoOn, currentLowerOn, torqueOnlyOn, brushlessOn, slowSpeedOn}, e,
			"flags");
	endtask : flags

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// watchdog: the whole run needs well under 3000 cycles
	initial begin
		#(40 * 20000);
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end

	// main sequence
	initial begin
		void'($urandom(32'hd50c27cd));
		for (int s = 1; s <= 3; s++) selM[s] = 8'h00;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		cyc(1);
		chk(fbSrc, 6'h15, "reset sources");
		obj(1'b0, 16'h3202, 8'h00, 32'h0);
		chk(rd, 32'h0, "submode reset");
		for (int k = 0; k < 8; k++) begin
			obj(1'b0, k < 4 ? 16'h3203 : 16'h3204, 8'(k % 4), 32'h0);
			tmp = (k % 4 == 0) ? 32'h3 : (k < 4) ? 32'h0 : 32'h3380 + 32'((k - 5) * 16);
			chk(rd, tmp, "table");
			chk({31'h0, er}, 32'h0, "table err");
		end
		// refused accesses: unmapped, read-only writes, bad subindex
		for (int k = 0; k < 4; k++) begin
			obj(k[0], k == 0 ? 16'h3205 : k == 1 ? 16'h3204 : k == 2 ? 16'h3202 : 16'h3203,
				k == 3 ? 8'h00 : 8'h01, 32'h5);
			chk({31'h0, er}, 32'h1, "refusal");
		end
		$display("test reset and refusals done");
		// sequencer: wait for index, then forced and requested alignment
		obj(1'b1, 16'h3202, 8'h00, 32'h1);
		cyc(6);
		chk({loopClosed, alignActive}, 2'b00, "waiting index");
		pulse(0);
		cyc(4);
		chk({31'h0, loopClosed}, 32'h1, "closed on index");
		for (int k = 0; k < 2; k++) begin
			obj(1'b1, 16'h3202, 8'h00, 32'h0);
			@(posedge clk);
			commHasIndex <= k[0];
			obj(1'b1, 16'h3202, 8'h00, k == 0 ? 32'h1 : 32'h11);
			cyc(5);
			chk({loopClosed, alignActive}, 2'b01, "aligning");
			pulse(1);
			cyc(4);
			chk({loopClosed, alignActive}, 2'b10, "closed after align");
		end
		subM = 32'h11;
		$display("test loop sequencer done");
		// loop type locked while enabled, other bits still stored
		@(posedge clk);
		opEnabled <= 1'b1;
		obj(1'b1, 16'h3202, 8'h00, 32'hA5000084);
		chk({31'h0, er}, 32'h1, "locked loop err");
		obj(1'b0, 16'h3202, 8'h00, 32'h0);
		chk(rd, 32'hA5000085, "locked loop kept");
		obj(1'b1, 16'h3202, 8'h00, 32'h00000081);
		chk({31'h0, er}, 32'h0, "same loop accepted");
		subM = 32'h81;
		$display("test loop lock done");
		// random masks and submode words; selections apply on entry to enabled
		@(posedge clk);
		indexSeen <= 1'b1;
		alignDone <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			for (int s = 1; s <= 3; s++) begin
				tmp = $urandom;
				selM[s] = tmp[7:0];
				obj(1'b1, 16'h3203, 8'(s), {24'h0, selM[s]});
				obj(1'b0, 16'h3203, 8'(s), 32'h0);
				chk(rd, {24'h0, selM[s]}, "mask readback");
			end
			chk(fbSrc, srcM, "no effect while enabled");
			@(posedge clk);
			opEnabled <= 1'b0;
			commHasIndex <= tmp[8];
			opMode <= modeTab[tmp[10:9]];
			subM = $urandom;
			obj(1'b1, 16'h3202, 8'h00, subM);
			chk({31'h0, er}, 32'h0, "submode write");
			flags();
			@(posedge clk);
			opEnabled <= 1'b1;
			cyc(4);
			srcM = search();
			chk(fbSrc, srcM, "sources");
		end
		$display("test random selection done");
		report_and_stop();
	end
endmodule : test_drive_submode_and_feedback_select
